// ===== fcrc_flash_rewrite_ctrl.sv
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module fcrc_flash_rewrite_ctrl
	import fcrc_pkg::*;
#(
	parameter int PROG_CYCLES = PROG_CYC,
	parameter int ERASE_CYCLES = ERASE_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// register port
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	// option byte as stored in flash
	input wire logic [7:0] flashOptByte,
	// flash array status from the macro
	input wire logic flashFail,
	// cpu and system side
	output logic cpuHold,
	output logic portFreeze,
	output logic cpuModeCtlBit,
	output logic romProtectOn,
	output logic csProtectOn,
	output logic readStatusMode,
	output logic optErased,
	output logic irq
);

	// ****************************************************************
	// parameter checks
	// ****************************************************************
	initial begin
		if (PROG_CYCLES < 1 || PROG_CYCLES > 65535) begin
			$error("PROG_CYCLES out of range");
		end
		if (ERASE_CYCLES < 1 || ERASE_CYCLES > 65535) begin
			$error("ERASE_CYCLES out of range");
		end
	end

	localparam logic [15:0] PROG_LOAD = 16'(PROG_CYCLES - 1);
	localparam logic [15:0] ERASE_LOAD = 16'(ERASE_CYCLES - 1);

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic inArea(input logic [7:0] b);
		inArea = (b >= BLK_ROM1_LO && b <= BLK_ROM1_HI) ||
			(b >= BLK_ROM2_LO && b <= BLK_ROM2_HI) ||
			(b >= BLK_DATA_LO && b <= BLK_DATA_HI);
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	fcrc_state_t state_q, state_d;
	fcrc_rdmode_t rdMode_q, rdMode_d;
	fcrc_opt_t opt_q;
	fcrc_op_t op_q;
	logic optLoaded_q;
	logic rewrite_q;
	logic stop_q;
	logic holdMode_q;
	logic perr_q, eerr_q;
	logic [7:0] cmdBlock_q;
	logic [7:0] execBlock_q;
	logic [2:0] irqSt_q, irqMask_q;
	logic [7:0] rdata_q;
	logic optErased_q;
	logic flashFailS1_q, flashFailS2_q;

	// ****************************************************************
	// decode
	// ****************************************************************
	wire wrCtrl = regWr && (regAddr == ADDR_CTRL0);
	wire wrMode = regWr && (regAddr == ADDR_MODE6);
	wire wrCmd = regWr && (regAddr == ADDR_CMD);
	wire wrAdr = regWr && (regAddr == ADDR_CMDADR);
	wire wrIrqSt = regWr && (regAddr == ADDR_IRQST);
	wire wrIrqMsk = regWr && (regAddr == ADDR_IRQMSK);
	wire wrExec = regWr && (regAddr == ADDR_EXEBLK);
	wire tmrRunning;
	wire busy = (state_q == FCRC_BUSY);
	wire ready = !(busy || tmrRunning) && !stop_q;
	wire cmdOk = rewrite_q && !stop_q && !busy;
	wire isProg = wrCmd && (regWdata == CMD_PROGRAM);
	wire isErase = wrCmd && (regWdata == CMD_ERASE);
	wire errBlock = perr_q || eerr_q;
	wire protBlock = holdMode_q && (cmdBlock_q == execBlock_q);
	wire opReq = cmdOk && (isProg || isErase) && !errBlock;
	wire opGo = opReq && inArea(cmdBlock_q) && !protBlock;
	wire opRefused = opReq && !opGo;
	wire rdStatusCmd = cmdOk && wrCmd && (regWdata == CMD_READ_STATUS);
	wire rdArrayCmd = cmdOk && wrCmd && (regWdata == CMD_READ_ARRAY);
	wire clrStatCmd = cmdOk && wrCmd && (regWdata == CMD_CLEAR_STATUS);
	wire tmrExpired;
	wire opDone = busy && tmrExpired;
	wire opFail = opDone && flashFailS2_q;
	wire [15:0] tmrLoad = isErase ? ERASE_LOAD : PROG_LOAD;
	wire [7:0] ctrlRead = {eerr_q, perr_q, 2'b00, stop_q, 1'b0,
		rewrite_q, ready};
	wire [7:0] statRead = {ready, 1'b0, eerr_q, perr_q, 4'h0};
	wire [2:0] irqEvt = {opRefused, opFail, opDone};

	// ****************************************************************
	// operation timer
	// ****************************************************************
	fcrc_timer #(
		.WIDTH(16)
	) u_timer (
		.ref_clk(ref_clk),
		.reset(reset),
		.start(opGo),
		.count(tmrLoad),
		.abort(stop_q),
		.running(tmrRunning),
		.expired(tmrExpired)
	);

	// ****************************************************************
	// option byte capture
	// ****************************************************************
	// sample once after reset release, hold until next reset
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			optLoaded_q <= 1'b0;
			opt_q <= '0;
		end else if (!optLoaded_q) begin
			optLoaded_q <= 1'b1;
			opt_q.romProtect <= !flashOptByte[OB_ROMCP];
			opt_q.csProtect <= !flashOptByte[OB_CSPRO];
		end
	end

	// ****************************************************************
	// synchroniser for flash macro fail
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			flashFailS1_q <= 1'b0;
			flashFailS2_q <= 1'b0;
		end else begin
			flashFailS1_q <= flashFail;
			flashFailS2_q <= flashFailS1_q;
		end
	end

	// ****************************************************************
	// control registers
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rewrite_q <= 1'b0;
			stop_q <= 1'b0;
			holdMode_q <= 1'b0;
			cmdBlock_q <= '0;
			execBlock_q <= '0;
			irqMask_q <= '0;
		end else begin
			if (wrCtrl) begin
				rewrite_q <= regWdata[C0_REWR];
				stop_q <= regWdata[C0_STOP] && regWdata[C0_REWR];
			end
			if (wrMode && !busy) begin
				holdMode_q <= regWdata[M6_HOLD];
			end
			if (wrAdr) begin
				cmdBlock_q <= regWdata;
			end
			if (wrExec) begin
				execBlock_q <= regWdata;
			end
			if (wrIrqMsk) begin
				irqMask_q <= regWdata[2:0];
			end
		end
	end

	// ****************************************************************
	// error flags, set wins over clear
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			perr_q <= 1'b0;
			eerr_q <= 1'b0;
		end else begin
			perr_q <= (perr_q && !clrStatCmd) || (opFail && op_q.isProgram);
			eerr_q <= (eerr_q && !clrStatCmd) || (opFail && op_q.isErase);
		end
	end

	// ****************************************************************
	// operation sequencer
	// ****************************************************************
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			FCRC_IDLE: begin
				if (opGo) begin
					state_d = FCRC_BUSY;
				end
			end
			FCRC_BUSY: begin
				if (stop_q) begin
					state_d = FCRC_IDLE;
				end else if (tmrExpired) begin
					state_d = FCRC_DONE;
				end
			end
			FCRC_DONE: begin
				state_d = FCRC_IDLE;
			end
			default: begin
				state_d = FCRC_IDLE;
			end
		endcase
	end

	// read mode after commands and completion
	always_comb begin
		rdMode_d = rdMode_q;
		if (!rewrite_q) begin
			rdMode_d = FCRC_RD_ARRAY;
		end else if (opGo || opDone) begin
			rdMode_d = holdMode_q ? FCRC_RD_ARRAY : FCRC_RD_STATUS;
		end else if (rdStatusCmd && !holdMode_q) begin
			rdMode_d = FCRC_RD_STATUS;
		end else if (rdArrayCmd) begin
			rdMode_d = FCRC_RD_ARRAY;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_q <= FCRC_IDLE;
			rdMode_q <= FCRC_RD_ARRAY;
			op_q <= '0;
		end else begin
			state_q <= state_d;
			rdMode_q <= rdMode_d;
			if (opGo) begin
				op_q <= '{isProgram: isProg, isErase: isErase,
					block: cmdBlock_q, data: regWdata};
			end
		end
	end

	// erased option byte block reads as ffh until reset or a later failed erase of it
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			optErased_q <= 1'b0;
		end else if (opDone && op_q.isErase && op_q.block == BLK_OPT) begin
			optErased_q <= !flashFailS2_q;
		end
	end

	// ****************************************************************
	// interrupts, write one to clear, set wins
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irqSt_q <= '0;
		end else begin
			irqSt_q <= (irqSt_q & ~(wrIrqSt ? regWdata[2:0] : 3'h0)) | irqEvt;
		end
	end

	// ****************************************************************
	// read port
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rdata_q <= '0;
		end else if (regRd) begin
			unique case (regAddr)
				ADDR_CTRL0: rdata_q <= ctrlRead;
				ADDR_MODE6: rdata_q <= {7'h00, holdMode_q};
				ADDR_CMDADR: rdata_q <= cmdBlock_q;
				ADDR_STAT: rdata_q <= holdMode_q ? 8'h00 : statRead;
				ADDR_OPT: rdata_q <= optErased_q ? OPT_ERASED : flashOptByte;
				ADDR_IRQST: rdata_q <= {5'h00, irqSt_q};
				ADDR_IRQMSK: rdata_q <= {5'h00, irqMask_q};
				ADDR_EXEBLK: rdata_q <= execBlock_q;
				default: rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= '0;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign regRdata = rdata_q;
	assign cpuHold = holdMode_q && busy;
	assign portFreeze = holdMode_q && busy;
	assign cpuModeCtlBit = rewrite_q;
	assign romProtectOn = opt_q.romProtect;
	assign csProtectOn = opt_q.csProtect;
	assign readStatusMode = (rdMode_q == FCRC_RD_STATUS);
	assign optErased = optErased_q;
	assign irq = |(irqSt_q & irqMask_q);

endmodule

// ===== fcrc_pkg.sv
// Notes on behaviour
// - rom_protect_cfg 0 enables ROM code protection, 1 disables it.
// - cs_protect_init 0 enables count-source protection after reset.
// - erasing the option byte block leaves the option byte at ffh.
// - program and erase act only inside ROM1, ROM2 and data flash blocks.
// - run mode keeps CPU running; hold mode holds CPU and freezes ports.
// - after operation: run mode stays status mode, hold mode reads array.
// - hold mode refuses program/erase aimed at the running control block.
// - read-status command unavailable in hold mode.
// - ready, program-error and erase-error flags readable in control reg.
// - run mode status register mirrors ready and error flags.
// - cpu_mode_ctl_bit forced to 1 while rewrite mode active.
// - rewrite_enable_bit 1 enters rewrite mode; ew_mode_select picks mode.
// - ready_busy_flag is 0 while an operation runs or flash stopped.
package fcrc_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [3:0] ADDR_CTRL0 = 4'h0;
	localparam logic [3:0] ADDR_MODE6 = 4'h1;
	localparam logic [3:0] ADDR_CMD = 4'h2;
	localparam logic [3:0] ADDR_CMDADR = 4'h3;
	localparam logic [3:0] ADDR_STAT = 4'h4;
	localparam logic [3:0] ADDR_OPT = 4'h5;
	localparam logic [3:0] ADDR_IRQST = 4'h6;
	localparam logic [3:0] ADDR_IRQMSK = 4'h7;
	localparam logic [3:0] ADDR_EXEBLK = 4'h8;

	// control register 0 fields
	localparam int C0_READY = 0;
	localparam int C0_REWR = 1;
	localparam int C0_STOP = 3;
	localparam int C0_PERR = 6;
	localparam int C0_EERR = 7;
	// mode register field
	localparam int M6_HOLD = 0;
	// status register fields
	localparam int SR_PERR = 4;
	localparam int SR_EERR = 5;
	localparam int SR_READY = 7;
	// option byte fields
	localparam int OB_ROMCP = 3;
	localparam int OB_CSPRO = 7;
	localparam logic [7:0] OPT_ERASED = 8'hff;
	// interrupt status fields
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERR = 1;
	localparam int IRQ_REFUSE = 2;

	// ****************************************************************
	// commands
	// ****************************************************************
	localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_PROGRAM = 8'h40;
	localparam logic [7:0] CMD_ERASE = 8'h20;

	// ****************************************************************
	// block area limits (block index units)
	// ****************************************************************
	localparam logic [7:0] BLK_ROM1_LO = 8'h00;
	localparam logic [7:0] BLK_ROM1_HI = 8'h0f;
	localparam logic [7:0] BLK_ROM2_LO = 8'h20;
	localparam logic [7:0] BLK_ROM2_HI = 8'h23;
	localparam logic [7:0] BLK_DATA_LO = 8'h40;
	localparam logic [7:0] BLK_DATA_HI = 8'h41;
	localparam logic [7:0] BLK_OPT = 8'h0f;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_MHZ = 25;
	localparam int PROG_TIME_US = 50;
	localparam int ERASE_TIME_US = 150;
	localparam int PROG_CYC = PROG_TIME_US * CLK_MHZ;
	localparam int ERASE_CYC = ERASE_TIME_US * CLK_MHZ;

	typedef enum logic [1:0] {
		FCRC_IDLE = 2'b00,
		FCRC_BUSY = 2'b01,
		FCRC_DONE = 2'b11
	} fcrc_state_t;

	typedef enum logic [1:0] {
		FCRC_RD_ARRAY = 2'b00,
		FCRC_RD_STATUS = 2'b01
	} fcrc_rdmode_t;

	// command from software
	typedef struct packed {
		logic isProgram;
		logic isErase;
		logic [7:0] block;
		logic [7:0] data;
	} fcrc_op_t;

	// option byte settings held since reset
	typedef struct packed {
		logic romProtect;
		logic csProtect;
	} fcrc_opt_t;

endpackage

// ===== fcrc_timer.sv
`timescale 1ns/1ps
module fcrc_timer
	import fcrc_pkg::*;
#(
	parameter int WIDTH = 16
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// control
	input wire logic start,
	input wire logic [WIDTH-1:0] count,
	input wire logic abort,
	// status
	output logic running,
	output logic expired
);

	initial begin
		if (WIDTH < 2) begin
			$error("fcrc_timer width too small");
		end
	end

	logic [WIDTH-1:0] cnt_q;
	logic run_q;
	logic lastTick;

	assign lastTick = run_q && (cnt_q == '0);
	assign running = run_q;
	assign expired = lastTick && !abort;

	// down counter for operation time
	always_ff @(posedge ref_clk) begin
		if (reset || abort) begin
			cnt_q <= '0;
			run_q <= 1'b0;
		end else if (start) begin
			cnt_q <= count;
			run_q <= 1'b1;
		end else if (lastTick) begin
			run_q <= 1'b0;
		end else if (run_q) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

endmodule

// ===== fcrc_flash_rewrite_ctrl_checker.sv
`timescale 1ns/1ps
module fcrc_flash_rewrite_ctrl_checker
	import fcrc_pkg::*;
#(
	parameter int PROG_CYCLES = PROG_CYC,
	parameter int ERASE_CYCLES = ERASE_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// register port
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdata,
	// flash side
	input wire logic [7:0] flashOptByte,
	input wire logic flashFail,
	// system side
	input wire logic cpuHold,
	input wire logic portFreeze,
	input wire logic cpuModeCtlBit,
	input wire logic romProtectOn,
	input wire logic csProtectOn,
	input wire logic readStatusMode,
	input wire logic optErased,
	input wire logic irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);

	// hold phase: starts on a command write, lasts one operation time
	sequence holdStart;
		$rose(cpuHold);
	endsequence
	sequence holdEnd;
		$fell(cpuHold);
	endsequence

	// cycles spent in the current hold phase
	logic [15:0] holdCnt_q;
	always_ff @(posedge ref_clk) begin
		if (reset || !cpuHold) begin
			holdCnt_q <= '0;
		end else begin
			holdCnt_q <= holdCnt_q + 1'b1;
		end
	end

	a_opt_held: assert property (
		!$past(reset) && !$past(reset, 2) |->
		$stable(romProtectOn) && $stable(csProtectOn)
	) else $error("option settings changed after capture");
	a_rom_polarity: assert property (
		!$past(reset) && !$past(reset, 2) |->
		romProtectOn == !flashOptByte[OB_ROMCP]
	) else $error("rom protection polarity wrong");
	a_cs_polarity: assert property (
		!$past(reset) && !$past(reset, 2) |->
		csProtectOn == !flashOptByte[OB_CSPRO]
	) else $error("count source protection polarity wrong");
	a_mode_bit: assert property (
		regWr && regAddr == ADDR_CTRL0 |=>
		cpuModeCtlBit == $past(regWdata[C0_REWR])
	) else $error("processor mode bit not following rewrite");
	a_hold_freeze: assert property (
		cpuHold == portFreeze
	) else $error("port freeze differs from cpu hold");
	a_hold_span: assert property (
		holdEnd |-> holdCnt_q == 16'(PROG_CYCLES) ||
		holdCnt_q == 16'(ERASE_CYCLES)
	) else $error("cpu hold span wrong");
	a_hold_start: assert property (
		holdStart |-> $past(regWr) && $past(regAddr) == ADDR_CMD
	) else $error("cpu hold without command write");
	a_rdata_idle: assert property (
		!$past(regRd) |-> regRdata == 8'h00
	) else $error("read data outside read slot");
	a_status_hidden: assert property (
		regRd && regAddr == ADDR_STAT && cpuHold |=> regRdata == 8'h00
	) else $error("status visible in hold mode");
	a_busy_flag: assert property (
		regRd && regAddr == ADDR_CTRL0 && cpuHold |=> !regRdata[C0_READY]
	) else $error("ready flag high while busy");
endmodule

// ===== fcrc_cpu_model.sv
`timescale 1ns/1ps
// cpu core issuing flash commands; runs from ram image
// raises no interrupt and no dma request while a hold-mode op runs
module fcrc_cpu_model
	import fcrc_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// register port
	output logic [3:0] regAddr,
	output logic [7:0] regWdata,
	output logic regWr,
	output logic regRd,
	input wire logic [7:0] regRdata
);
	// idle bus at time zero
	initial begin
		regAddr = 4'h0;
		regWdata = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
	end

	// one-cycle write, data line scrambled after release
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
		regWdata <= ~d;
		#1;
	endtask

	// one-cycle read, data taken in the following cycle
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask
endmodule

// ===== fcrc_flash_rewrite_ctrl_tb.sv
`timescale 1ns/1ps
module fcrc_flash_rewrite_ctrl_tb
	import fcrc_pkg::*;
();
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] regAddr;
	logic [7:0] regWdata;
	logic regWr;
	logic regRd;
	logic [7:0] regRdata;
	logic [7:0] flashOptByte = 8'h76;
	logic flashFail = 1'b0;
	logic cpuHold;
	logic portFreeze;
	logic cpuModeCtlBit;
	logic romProtectOn;
	logic csProtectOn;
	logic readStatusMode;
	logic optErased;
	logic irq;
	int errorCnt = 0;
	int totalChecks = 0;
	logic [7:0] blkTab [6] = '{BLK_ROM1_LO, BLK_ROM2_HI, BLK_DATA_LO,
		8'h10, 8'h24, 8'h42};

	// design and cpu model
	fcrc_flash_rewrite_ctrl #(.PROG_CYCLES(4), .ERASE_CYCLES(4)) uut (
		.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .flashOptByte(flashOptByte),
		.flashFail(flashFail), .cpuHold(cpuHold), .portFreeze(portFreeze),
		.cpuModeCtlBit(cpuModeCtlBit), .romProtectOn(romProtectOn),
		.csProtectOn(csProtectOn), .readStatusMode(readStatusMode),
		.optErased(optErased), .irq(irq));
	fcrc_cpu_model cpu (
		.ref_clk(ref_clk), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata));

	// clock
	initial begin
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic chk(input string nm, input logic [7:0] exp,
		input logic [7:0] got);
		totalChecks++;
		if (got !== exp) begin
			errorCnt++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] exp,
		input string nm);
		logic [7:0] d;
		cpu.rd(a, d);
		chk(nm, exp, d);
	endtask
	task automatic op(input logic [7:0] blk, input logic [7:0] c);
		cpu.wr(ADDR_CMDADR, blk);
		cpu.wr(ADDR_CMD, c);
	endtask
	task automatic waitRdy();
		logic [7:0] d = 8'h00;
		for (int i = 0; i < 20 && !d[C0_READY]; i++) cpu.rd(ADDR_CTRL0, d);
		chk("ready", 8'h01, {7'h00, d[C0_READY]});
	endtask
	// option image keeps wdt autostart 0 beside cs protect 0
	task automatic doReset(input logic [7:0] opt);
		@(posedge ref_clk);
		reset <= 1'b1;
		flashOptByte <= opt;
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask
	task automatic tend(input int n);
		$display("test %0d done", n);
	endtask
	task automatic endOfTest();
		$display("checks %0d mismatches %0d", totalChecks, errorCnt);
		if (errorCnt == 0 && totalChecks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// watchdog
	initial begin
		repeat (20000) @(posedge ref_clk);
		errorCnt++;
		endOfTest();
	end

	// test sequence
	initial begin
		doReset(8'h76);
		chk("romProtectOn", 8'h01, romProtectOn);
		chk("csProtectOn", 8'h01, csProtectOn);
		rdc(ADDR_OPT, 8'h76, "option");
		tend(1);
		op(BLK_ROM1_LO, CMD_PROGRAM);
		rdc(ADDR_CTRL0, 8'h01, "ctrl0 off");
		rdc(ADDR_IRQST, 8'h00, "irq off");
		cpu.wr(ADDR_IRQST, 8'h04);
		rdc(ADDR_IRQST, 8'h00, "irq clear");
		tend(2);
		cpu.wr(ADDR_IRQMSK, 8'h01);
		cpu.wr(ADDR_CTRL0, 8'h02);
		chk("cpuModeCtlBit", 8'h01, cpuModeCtlBit);
		rdc(ADDR_CTRL0, 8'h03, "ctrl0");
		op(BLK_DATA_HI, CMD_PROGRAM);
		chk("cpuHold run", 8'h00, cpuHold);
		rdc(ADDR_CTRL0, 8'h02, "ctrl0 busy");
		waitRdy();
		chk("readStatusMode", 8'h01, readStatusMode);
		rdc(ADDR_STAT, 8'h80, "status");
		chk("irq", 8'h01, irq);
		cpu.wr(ADDR_IRQST, 8'h01);
		chk("irq cleared", 8'h00, irq);
		tend(3);
		for (int i = 0; i < 6; i++) begin
			op(blkTab[i], CMD_ERASE);
			waitRdy();
			rdc(ADDR_IRQST, (i < 3) ? 8'h01 : 8'h04, "area");
			cpu.wr(ADDR_IRQST, 8'h07);
		end
		tend(4);
		op(BLK_OPT, CMD_ERASE);
		waitRdy();
		chk("optErased", 8'h01, optErased);
		rdc(ADDR_OPT, OPT_ERASED, "option erased");
		chk("romProtectOn held", 8'h01, romProtectOn);
		cpu.wr(ADDR_IRQST, 8'h07);
		tend(5);
		@(posedge ref_clk) flashFail <= 1'b1;
		op(BLK_ROM1_LO, CMD_PROGRAM);
		waitRdy();
		@(posedge ref_clk) flashFail <= 1'b0;
		rdc(ADDR_CTRL0, 8'h43, "ctrl0 perr");
		rdc(ADDR_STAT, 8'h90, "status perr");
		op(BLK_ROM1_LO, CMD_PROGRAM);
		rdc(ADDR_CTRL0, 8'h43, "ctrl0 refused");
		rdc(ADDR_IRQST, 8'h03, "irq fail");
		cpu.wr(ADDR_CMD, CMD_CLEAR_STATUS);
		rdc(ADDR_CTRL0, 8'h03, "ctrl0 clear");
		cpu.wr(ADDR_CMD, CMD_READ_ARRAY);
		chk("read array", 8'h00, readStatusMode);
		cpu.wr(ADDR_CMD, CMD_READ_STATUS);
		chk("read status", 8'h01, readStatusMode);
		cpu.wr(ADDR_CTRL0, 8'h0a);
		rdc(ADDR_CTRL0, 8'h0a, "ctrl0 stop");
		cpu.wr(ADDR_CTRL0, 8'h02);
		@(posedge ref_clk) flashFail <= 1'b1;
		op(BLK_DATA_LO, CMD_ERASE);
		waitRdy();
		@(posedge ref_clk) flashFail <= 1'b0;
		rdc(ADDR_CTRL0, 8'h83, "ctrl0 eerr");
		rdc(ADDR_STAT, 8'ha0, "status eerr");
		cpu.wr(ADDR_CMD, CMD_CLEAR_STATUS);
		cpu.wr(ADDR_IRQST, 8'h07);
		tend(6);
		cpu.wr(ADDR_MODE6, 8'h01);
		cpu.wr(ADDR_EXEBLK, BLK_ROM2_LO);
		op(BLK_ROM2_LO, CMD_ERASE);
		rdc(ADDR_IRQST, 8'h04, "exec block");
		cpu.wr(ADDR_IRQST, 8'h07);
		op(BLK_ROM2_HI, CMD_PROGRAM);
		chk("cpuHold", 8'h01, cpuHold);
		chk("portFreeze", 8'h01, portFreeze);
		rdc(ADDR_STAT, 8'h00, "status hold");
		waitRdy();
		chk("cpuHold end", 8'h00, cpuHold);
		chk("readStatusMode hold", 8'h00, readStatusMode);
		cpu.wr(ADDR_CMD, CMD_READ_STATUS);
		chk("read status hold", 8'h00, readStatusMode);
		tend(7);
		chk("irq hold", 8'h01, irq);
		cpu.wr(ADDR_IRQMSK, 8'h00);
		chk("irq masked", 8'h00, irq);
		rdc(4'hf, 8'h00, "unmapped");
		tend(8);
		doReset(8'hff);
		chk("romProtectOn off", 8'h00, romProtectOn);
		chk("csProtectOn off", 8'h00, csProtectOn);
		chk("cpuModeCtlBit off", 8'h00, cpuModeCtlBit);
		rdc(ADDR_CTRL0, 8'h01, "ctrl0 reset");
		tend(9);
		endOfTest();
	end
endmodule

bind fcrc_flash_rewrite_ctrl fcrc_flash_rewrite_ctrl_checker #(
	.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) uChk (
	.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
	.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
	.regRdata(regRdata), .flashOptByte(flashOptByte),
	.flashFail(flashFail), .cpuHold(cpuHold), .portFreeze(portFreeze),
	.cpuModeCtlBit(cpuModeCtlBit), .romProtectOn(romProtectOn),
	.csProtectOn(csProtectOn), .readStatusMode(readStatusMode),
	.optErased(optErased), .irq(irq));
